// ===== logic/wave_timer.v
// dual-output waveform timer with fault inputs and apb registers
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wave_timer_consts.vh"

module wave_timer #(
   parameter CW = 12
) (
   input  wire          clk_sys,
   input  wire          sys_rst,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output wire [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   input  wire          event_in_a,
   input  wire          event_in_b,
   output wire          wave_out_a,
   output wire          wave_out_b
);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   reg              enable_reg;
   reg [1:0]        waveform_mode_field;
   reg [7:0]        evctrl_a_reg;
   reg [7:0]        evctrl_b_reg;
   reg [7:0]        dlyctrl_reg;
   reg [7:0]        delay_count_value_reg;
   reg [CW-1:0]     a_set_buf, a_clr_buf, b_set_buf, b_clr_buf;
   reg [CW-1:0]     a_set_compare, a_clear_compare, b_set_compare, b_clear_compare;
   reg              update_pend_reg;
   reg              dis_pend_reg;
   reg [CW-1:0]     capt_a_reg, capt_b_reg;
   reg [31:0]       prdata_reg;
   reg              rd_wait_reg;

   wire wr = psel & penable & pwrite;
   wire rd = psel & penable & ~pwrite;
   wire hit = (paddr[11:6] == 6'h00) && (paddr[5:2] <= 4'hB) && (paddr[1:0] == 2'h0);
   wire [5:0] strobe = (wr && paddr == `ADDR_STROBE) ? pwdata[5:0] : 6'h00;

   // reads take one wait state so that prdata comes from a flop at the ready edge
   assign pready  = ~rd | rd_wait_reg;
   assign pslverr = psel & penable & ~hit;
   assign prdata  = prdata_reg;

   // event control byte: [0] trigger_input_enable [1] action capture [2] filter
   // [3] async detect [7:4] fault_mode_field
   wire trig_en_a = evctrl_a_reg[0];
   wire trig_en_b = evctrl_b_reg[0];
   wire [3:0] fm_a = evctrl_a_reg[7:4];
   wire [3:0] fm_b = evctrl_b_reg[7:4];

   ////////////////////////////////////////////////////////////////////////////
   // input synchroniser, filter, blanking
   reg [1:0] sync_a, sync_b;
   reg [`FILT_LEN-1:0] hist_a, hist_b;
   reg filt_a, filt_b;
   reg prev_a, prev_b;

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sync_a <= 2'h0;
         sync_b <= 2'h0;
         hist_a <= {`FILT_LEN{1'b0}};
         hist_b <= {`FILT_LEN{1'b0}};
         filt_a <= 1'b0;
         filt_b <= 1'b0;
      end else begin
         sync_a <= {sync_a[0], event_in_a};
         sync_b <= {sync_b[0], event_in_b};
         hist_a <= {hist_a[`FILT_LEN-2:0], sync_a[1]};
         hist_b <= {hist_b[`FILT_LEN-2:0], sync_b[1]};
         // a level passes only after four equal samples
         if (&hist_a)
            filt_a <= 1'b1;
         else if (~|hist_a)
            filt_a <= 1'b0;
         if (&hist_b)
            filt_b <= 1'b1;
         else if (~|hist_b)
            filt_b <= 1'b0;
      end
   end

   // blanking on input a: dlyctrl [1:0] select (1=blank) [3:2] trigger [5:4] prescale
   reg [7:0] presc_cnt;
   reg [7:0] dly_cnt;
   reg       blank_reg;
   wire blank_sel = (dlyctrl_reg[1:0] == 2'h1); // one circuit, blanking use only
   wire ph_edge;
   wire [7:0] presc_top = (8'h01 << dlyctrl_reg[5:4]) - 8'h01;

   // asynchronous detection takes the unfiltered path, so the two never combine
   wire raw_a = (evctrl_a_reg[2] & ~evctrl_a_reg[3]) ? filt_a : sync_a[1];
   wire raw_b = (evctrl_b_reg[2] & ~evctrl_b_reg[3]) ? filt_b : sync_b[1];
   wire ev_a = trig_en_a & raw_a & ~blank_reg;
   wire ev_b = trig_en_b & raw_b;
   wire cap_a_ev = ev_a & ~prev_a & evctrl_a_reg[1];
   wire cap_b_ev = ev_b & ~prev_b & evctrl_b_reg[1];
   // fault mode zero or capture action means no fault
   wire flt_a = ev_a & ~evctrl_a_reg[1] & (fm_a != `FM_NONE);
   wire flt_b = ev_b & ~evctrl_b_reg[1] & (fm_b != `FM_NONE);

   // last value of each qualified event, for edge detection
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prev_a <= 1'b0;
         prev_b <= 1'b0;
      end else begin
         prev_a <= ev_a;
         prev_b <= ev_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter and phase
   reg [CW-1:0] cnt_reg;
   reg [1:0]    phase_reg;
   reg          down_reg;
   reg          first_reg;
   reg          out_a_reg, out_b_reg;
   reg          halt_reg;
   reg          cut_a_reg, cut_b_reg;
   // one counter step at the counter's own width
   localparam [CW-1:0] CNT_STEP = {{(CW-1){1'b0}}, 1'b1};

   function [CW-1:0] ramp_top;
      input [1:0] mode;
      input [1:0] ph;
      input [CW-1:0] as, ac, bs, bc;
      begin
         case (mode)
            `WG_TWO_RAMP:  ramp_top = ph[1] ? bc : ac;
            `WG_FOUR_RAMP: case (ph)
                              `PH_DTA: ramp_top = as;
                              `PH_OTA: ramp_top = ac;
                              `PH_DTB: ramp_top = bs;
                              default: ramp_top = bc;
                           endcase
            default:       ramp_top = bc;
         endcase
      end
   endfunction

   wire [CW-1:0] top = ramp_top(waveform_mode_field, phase_reg, a_set_compare,
                                a_clear_compare, b_set_compare, b_clear_compare);
   wire dual = (waveform_mode_field == `WG_DUAL_SLOPE);
   wire at_top = (cnt_reg == top);
   wire cyc_end = enable_reg & ~halt_reg & (dual ? (~down_reg & at_top)
                  : (at_top && (waveform_mode_field == `WG_ONE_RAMP
                  || phase_reg == `PH_OTB || waveform_mode_field == `WG_TWO_RAMP
                  && phase_reg[1])));
   assign ph_edge = enable_reg & ~halt_reg & ~dual & at_top;

   // stop-and-wait mode halts counting until restart; level modes never halt
   wire halt_set = (flt_a && fm_a == `FM_WAIT_SW) || (flt_b && fm_b == `FM_WAIT_SW);
   wire stop_all = (flt_a && fm_a == `FM_STOP_ALL) || (flt_b && fm_b == `FM_STOP_ALL);
   wire edge_a = flt_a & ~prev_a;
   wire edge_b = flt_b & ~prev_b;

   // asynchronous override path bypasses the synchroniser
   wire async_a = evctrl_a_reg[3] & trig_en_a & ~evctrl_a_reg[1] & (fm_a != `FM_NONE)
                  & event_in_a;
   wire async_b = evctrl_b_reg[3] & trig_en_b & ~evctrl_b_reg[1] & (fm_b != `FM_NONE)
                  & event_in_b;
   wire kill_a = stop_all | halt_reg | cut_a_reg | (flt_a && fm_a == `FM_LEVEL_HOLD);
   wire kill_b = stop_all | halt_reg | cut_b_reg | (flt_b && fm_b == `FM_LEVEL_HOLD);
   assign wave_out_a = out_a_reg & enable_reg & ~kill_a & ~async_a & ~async_b;
   assign wave_out_b = out_b_reg & enable_reg & ~kill_b & ~async_a & ~async_b;

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         enable_reg          <= 1'b0;
         waveform_mode_field <= `WG_ONE_RAMP;
         evctrl_a_reg        <= 8'h00;
         evctrl_b_reg        <= 8'h00;
         dlyctrl_reg         <= 8'h00;
         delay_count_value_reg          <= 8'h00;
         a_set_buf           <= `CNT_ZERO;
         a_clr_buf           <= `CNT_ZERO;
         b_set_buf           <= `CNT_ZERO;
         b_clr_buf           <= `CNT_ZERO;
         a_set_compare       <= `CNT_ZERO;
         a_clear_compare     <= `CNT_ZERO;
         b_set_compare       <= `CNT_ZERO;
         b_clear_compare     <= `CNT_ZERO;
         update_pend_reg     <= 1'b0;
         dis_pend_reg        <= 1'b0;
         capt_a_reg          <= `CNT_ZERO;
         capt_b_reg          <= `CNT_ZERO;
         prdata_reg          <= 32'h00000000;
         rd_wait_reg         <= 1'b0;
         cnt_reg             <= `CNT_ZERO;
         phase_reg           <= `PH_DTA;
         down_reg            <= 1'b0;
         first_reg           <= 1'b0;
         out_a_reg           <= 1'b0;
         out_b_reg           <= 1'b0;
         halt_reg            <= 1'b0;
         cut_a_reg           <= 1'b0;
         cut_b_reg           <= 1'b0;
         presc_cnt           <= 8'h00;
         dly_cnt             <= 8'h00;
         blank_reg           <= 1'b0;
      end else begin
         // register writes; static fields only while disabled
         if (wr) begin
            case (paddr)
               `ADDR_CTRL: begin
                  enable_reg <= pwdata[0];
                  if (!enable_reg) waveform_mode_field <= pwdata[2:1];
                  if (pwdata[0] && !enable_reg) begin
                     a_set_compare   <= a_set_buf;
                     a_clear_compare <= a_clr_buf;
                     b_set_compare   <= b_set_buf;
                     b_clear_compare <= b_clr_buf;
                     down_reg        <= (pwdata[2:1] == `WG_DUAL_SLOPE);
                     cnt_reg         <= (pwdata[2:1] == `WG_DUAL_SLOPE) ? b_clr_buf
                                        : `CNT_ZERO;
                     first_reg       <= 1'b1;
                     phase_reg       <= `PH_DTA;
                  end
               end
               `ADDR_EVCTRL:  if (!enable_reg) begin
                  evctrl_a_reg <= pwdata[7:0];
                  evctrl_b_reg <= pwdata[15:8];
               end
               `ADDR_DLYCTRL: dlyctrl_reg <= pwdata[7:0];
               `ADDR_DELAY_COUNT_VALUE:  delay_count_value_reg  <= pwdata[7:0];
               `ADDR_A_SET:   a_set_buf   <= pwdata[CW-1:0];
               `ADDR_A_CLR:   a_clr_buf   <= pwdata[CW-1:0];
               `ADDR_B_SET:   b_set_buf   <= pwdata[CW-1:0];
               `ADDR_B_CLR:   b_clr_buf   <= pwdata[CW-1:0];
               default: ;
            endcase
         end
         rd_wait_reg <= rd & ~rd_wait_reg;
         if (rd && !rd_wait_reg) begin
            case (paddr)
               `ADDR_CTRL:    prdata_reg <= {29'h0, waveform_mode_field, enable_reg};
               `ADDR_EVCTRL:  prdata_reg <= {16'h0, evctrl_b_reg, evctrl_a_reg};
               `ADDR_DLYCTRL: prdata_reg <= {24'h0, dlyctrl_reg};
               `ADDR_DELAY_COUNT_VALUE:  prdata_reg <= {24'h0, delay_count_value_reg};
               `ADDR_A_SET:   prdata_reg <= {20'h0, a_set_buf};
               `ADDR_A_CLR:   prdata_reg <= {20'h0, a_clr_buf};
               `ADDR_B_SET:   prdata_reg <= {20'h0, b_set_buf};
               `ADDR_B_CLR:   prdata_reg <= {20'h0, b_clr_buf};
               `ADDR_STATUS:  prdata_reg <= {16'h0, cnt_reg, halt_reg, dis_pend_reg,
                                            update_pend_reg, enable_reg};
               `ADDR_CAPT_A:  prdata_reg <= {20'h0, capt_a_reg};
               `ADDR_CAPT_B:  prdata_reg <= {20'h0, capt_b_reg};
               default:       prdata_reg <= 32'h00000000;
            endcase
         end

         // command strobes
         if (strobe[`STB_SYNC] || (update_pend_reg && cyc_end)) begin
            a_set_compare   <= a_set_buf;
            a_clear_compare <= a_clr_buf;
            b_set_compare   <= b_set_buf;
            b_clear_compare <= b_clr_buf;
            update_pend_reg <= 1'b0;
         end
         if (strobe[`STB_SYNC_EOC] && enable_reg) update_pend_reg <= 1'b1;
         if (strobe[`STB_DIS_EOC] && enable_reg) dis_pend_reg <= 1'b1;
         if (strobe[`STB_CAPT_A] || cap_a_ev) capt_a_reg <= cnt_reg;
         if (strobe[`STB_CAPT_B] || cap_b_ev) capt_b_reg <= cnt_reg;

         // blanking delay: triggered at each ramp end, never in dual slope mode
         if (blank_sel && ph_edge) begin
            blank_reg <= (delay_count_value_reg != 8'h00);
            dly_cnt   <= 8'h00;
            presc_cnt <= 8'h00;
         end else if (blank_reg) begin
            presc_cnt <= (presc_cnt == presc_top) ? 8'h00 : presc_cnt + 8'h01;
            if (presc_cnt == presc_top) begin
               dly_cnt <= dly_cnt + 8'h01;
               if (dly_cnt + 8'h01 == delay_count_value_reg) blank_reg <= 1'b0;
            end
         end

         // fault effects on flow follow the synchronised event
         if (halt_set) halt_reg <= 1'b1;
         else if (strobe[`STB_RESTART]) halt_reg <= 1'b0;
         if (edge_a && fm_a == `FM_EDGE_HOLD && out_a_reg) cut_a_reg <= 1'b1;
         if (edge_b && fm_b == `FM_EDGE_HOLD && out_b_reg) cut_b_reg <= 1'b1;

         if (!enable_reg) begin
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
         end else if (strobe[`STB_RESTART]) begin
            cnt_reg   <= dual ? b_clear_compare : `CNT_ZERO;
            down_reg  <= dual;
            phase_reg <= `PH_DTA;
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
         end else if (!halt_reg) begin
            if (cyc_end && dis_pend_reg) begin
               enable_reg   <= 1'b0;
               dis_pend_reg <= 1'b0;
            end
            case (waveform_mode_field)
               `WG_DUAL_SLOPE: begin
                  // a_clear_compare is never consulted here
                  if (down_reg) begin
                     if (cnt_reg == a_set_compare) out_a_reg <= 1'b1;
                     if (cnt_reg == b_set_compare) out_b_reg <= 1'b0;
                     if (cnt_reg == `CNT_ZERO) down_reg <= 1'b0;
                     else cnt_reg <= cnt_reg - CNT_STEP;
                  end else begin
                     if (cnt_reg == a_set_compare) out_a_reg <= 1'b0;
                     if (cnt_reg == b_set_compare) begin
                        out_b_reg <= 1'b1;
                        first_reg <= 1'b0;
                     end
                     if (at_top) begin
                        down_reg  <= 1'b1;
                        cut_a_reg <= 1'b0;
                        cut_b_reg <= 1'b0;
                     end else cnt_reg <= cnt_reg + CNT_STEP;
                  end
               end
               `WG_ONE_RAMP: begin
                  if (cnt_reg == a_set_compare) out_a_reg <= 1'b1;
                  if (cnt_reg == a_clear_compare && a_clear_compare >= a_set_compare)
                     out_a_reg <= 1'b0;
                  if (cnt_reg == b_set_compare) out_b_reg <= 1'b1;
                  if (at_top) begin
                     out_a_reg <= 1'b0;
                     out_b_reg <= 1'b0;
                     cnt_reg   <= `CNT_ZERO;
                     cut_a_reg <= 1'b0;
                     cut_b_reg <= 1'b0;
                  end else cnt_reg <= cnt_reg + CNT_STEP;
               end
               `WG_TWO_RAMP: begin
                  // set compare above clear never matches as the ramp ends first
                  if (!phase_reg[1] && cnt_reg == a_set_compare) out_a_reg <= 1'b1;
                  if (phase_reg[1] && cnt_reg == b_set_compare) out_b_reg <= 1'b1;
                  if (at_top) begin
                     out_a_reg <= 1'b0;
                     out_b_reg <= 1'b0;
                     cnt_reg   <= `CNT_ZERO;
                     phase_reg <= phase_reg[1] ? `PH_DTA : `PH_DTB;
                     cut_a_reg <= 1'b0;
                     cut_b_reg <= 1'b0;
                  end else cnt_reg <= cnt_reg + CNT_STEP;
               end
               default: begin
                  // four ramps map onto dead a, on a, dead b, on b
                  if (at_top) begin
                     cnt_reg   <= `CNT_ZERO;
                     phase_reg <= phase_reg + 2'h1;
                     out_a_reg <= (phase_reg == `PH_DTA);
                     out_b_reg <= (phase_reg == `PH_DTB);
                     cut_a_reg <= 1'b0;
                     cut_b_reg <= 1'b0;
                  end else cnt_reg <= cnt_reg + CNT_STEP;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ===== logic/wave_timer_consts.vh
// constants and register map of the dual-output waveform timer
//
// Overview of operation
// - single ramp: count 0..b_clear_compare then restart; period b_clear+1
// - single ramp: b_clear match clears both outputs; larger compares never act
// - single ramp: a_clear below a_set has no effect on output a
// - two ramp: ramp 0..a_clear then 0..b_clear; period sum of both plus two
// - two ramp: set values above their clear value are never reached
// - four ramp: ramps end at a_set, a_clear, b_set, b_clear in turn
// - dual slope: count down from b_clear to zero and up again
// - dual slope: a set on downward a_set match, cleared on upward match
// - dual slope: b set on upward b_set match, cleared on downward match
// - dual slope: a_clear compare is ignored
// - dual slope start: begin at b_clear going down, b stays off until first upward b_set match
// - enable low stops at once; end-cycle strobe stops at cycle end
// - event input acts only when enabled; fault by default, capture if action set
// - fault mode zero disables fault detection; four fault modes are defined
// - override after two to three clocks; asynchronous detection overrides at once
// - blanking on input a masks events until prescaled counter reaches delay value
// - blanking and output event share one delay circuit, never both
// - filter drops pulses under four clocks; changes pass after four clocks
// - asynchronous detection overrides outputs; flow changes after synchronising
// - asynchronous detection and filter must not both be enabled
// - strobes: update at cycle end, update now, restart, capture a or b
// - mode field selects counting; four ramp cycle passes dead a, on a, dead b, on b
`ifndef WAVE_TIMER_CONSTS_VH
`define WAVE_TIMER_CONSTS_VH

`define ADDR_CTRL      12'h000
`define ADDR_STROBE    12'h004
`define ADDR_EVCTRL    12'h008
`define ADDR_DLYCTRL   12'h00C
`define ADDR_DELAY_COUNT_VALUE    12'h010
`define ADDR_A_SET     12'h014
`define ADDR_A_CLR     12'h018
`define ADDR_B_SET     12'h01C
`define ADDR_B_CLR     12'h020
`define ADDR_STATUS    12'h024
`define ADDR_CAPT_A    12'h028
`define ADDR_CAPT_B    12'h02C

`define WG_ONE_RAMP    2'h0
`define WG_TWO_RAMP    2'h1
`define WG_FOUR_RAMP   2'h2
`define WG_DUAL_SLOPE  2'h3

`define PH_DTA         2'h0
`define PH_OTA         2'h1
`define PH_DTB         2'h2
`define PH_OTB         2'h3

`define FM_NONE        4'h0
`define FM_STOP_ALL    4'h4
`define FM_WAIT_SW     4'h7
`define FM_EDGE_HOLD   4'h9
`define FM_LEVEL_HOLD  4'hA

`define STB_SYNC_EOC   0
`define STB_SYNC       1
`define STB_RESTART    2
`define STB_CAPT_A     3
`define STB_CAPT_B     4
`define STB_DIS_EOC    5

`define FILT_LEN       4
`define CNT_ZERO       12'h000

`endif

// ===== tb/dual_output_pwm_with_fault_inputs_tb.sv
// self-checking bench of the waveform timer
`timescale 1ns/1ps
`default_nettype none
`include "wave_timer_consts.vh"
module dual_output_pwm_with_fault_inputs_tb;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic        want_a  = 1'b0;
   logic        want_b  = 1'b0;
   wire  [31:0] prdata;
   wire         pready, pslverr, event_in_a, event_in_b, wave_out_a, wave_out_b;
   logic [31:0] rv;
   logic        ev, hi;
   int          fails = 0, tests_run = 0, p;
   logic [1:0]  md  [4] = '{`WG_ONE_RAMP, `WG_TWO_RAMP, `WG_FOUR_RAMP, `WG_DUAL_SLOPE};
   int          per [4] = '{12, 20, 32, 24};
   logic [11:0] cmp [4] = '{12'h002, 12'h007, 12'h008, 12'h00B};
   logic [15:0] evc [4] = '{16'h0040, 16'h0001, 16'h0041, 16'h0049};
   logic        blk [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   always #10 clk_sys = ~clk_sys;
   wave_timer uut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .event_in_a, .event_in_b, .wave_out_a, .wave_out_b);
   event_source far (.clk_sys, .want_a, .want_b, .event_in_a, .event_in_b);
   ////////////////////////////////////////////////////////////////////////////////
   task print_verdict;
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   // one apb transfer; read data and error are taken at the ready edge
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
         print_verdict();
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_rise(output int n);
      logic pa, seen;
      n = 0;
      pa = 1'b1;
      seen = 1'b0;
      do begin
         @(negedge clk_sys);
         n++;
         seen = (pa === 1'b0 && wave_out_a === 1'b1);
         pa = wave_out_a;
      end while (!seen && n <= 200);
      if (!seen) begin
         fails++;
         print_verdict();
      end
   endtask
   task period_is(input int exp);
      wait_rise(p);
      wait_rise(p);
      check(p, exp, "cycle length");
   endtask
   task watch(input int c);
      hi = 1'b0;
      repeat (c) begin
         @(negedge clk_sys);
         if (wave_out_a !== 1'b0 || wave_out_b !== 1'b0) hi = 1'b1;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      check({30'h0, wave_out_b, wave_out_a}, 32'h0, "outputs after reset");
      for (int i = 0; i < 4; i++) begin
         apb(`ADDR_A_SET + 12'(4 * i), 1'b1, {20'h0, cmp[i]});
         apb(`ADDR_A_SET + 12'(4 * i), 1'b0, 32'h0);
         check(rv, {20'h0, cmp[i]}, "compare readback");
      end
      apb(12'h030, 1'b0, 32'h0);
      check({31'h0, ev}, 32'h1, "unmapped error");
      for (int i = 0; i < 4; i++) begin
         apb(`ADDR_CTRL, 1'b1, 32'h0);
         apb(`ADDR_CTRL, 1'b1, {29'h0, md[i], 1'b1});
         period_is(per[i]);
      end
      apb(`ADDR_CTRL, 1'b1, 32'h0);
      apb(`ADDR_CTRL, 1'b1, 32'h1);
      apb(`ADDR_B_CLR, 1'b1, 32'h5);
      period_is(12);
      apb(`ADDR_STROBE, 1'b1, 32'h1);
      period_is(6);
      apb(`ADDR_B_CLR, 1'b1, 32'hB);
      apb(`ADDR_STROBE, 1'b1, 32'h2);
      for (int i = 0; i < 4; i++) begin
         apb(`ADDR_CTRL, 1'b1, 32'h0);
         apb(`ADDR_EVCTRL, 1'b1, {16'h0, evc[i]});
         apb(`ADDR_CTRL, 1'b1, 32'h1);
         wait_rise(p);
         @(posedge clk_sys);
         want_a <= 1'b1;
         @(posedge clk_sys);
         @(negedge clk_sys);
         if (evc[i][3]) check({31'h0, wave_out_a}, 32'h0, "direct override");
         repeat (3) @(negedge clk_sys);
         watch(40);
         check({31'h0, hi}, {31'h0, !blk[i]}, "fault gating");
         @(posedge clk_sys);
         want_a <= 1'b0;
      end
      apb(`ADDR_CTRL, 1'b1, 32'h0);
      apb(`ADDR_EVCTRL, 1'b1, 32'h0);
      apb(`ADDR_CTRL, 1'b1, 32'h1);
      wait_rise(p);
      apb(`ADDR_STROBE, 1'b1, 32'h20);
      @(negedge clk_sys);
      check({31'h0, wave_out_a}, 32'h1, "runs to cycle end");
      repeat (20) @(negedge clk_sys);
      apb(`ADDR_STATUS, 1'b0, 32'h0);
      check({31'h0, rv[0]}, 32'h0, "stopped at cycle end");
      watch(30);
      check({31'h0, hi}, 32'h0, "quiet after stop");
      apb(`ADDR_CTRL, 1'b1, 32'h1);
      wait_rise(p);
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      @(negedge clk_sys);
      check({30'h0, wave_out_b, wave_out_a}, 32'h0, "outputs in reset");
      @(posedge clk_sys);
      sys_rst <= 1'b0;
      apb(`ADDR_STATUS, 1'b0, 32'h0);
      check({31'h0, rv[0]}, 32'h0, "disabled after reset");
      print_verdict();
   end
endmodule
`default_nettype wire

// ===== tb/event_source.sv
// far-side event network model driving the timer's event inputs
`timescale 1ns/1ps
`default_nettype none
module event_source (
   input  wire logic clk_sys,
   input  wire logic want_a,
   input  wire logic want_b,
   output var  logic event_in_a,
   output var  logic event_in_b
);
   initial begin
      event_in_a = 1'b0;
      event_in_b = 1'b0;
   end
   // event levels move just after the clock edge, as routed events do
   always @(posedge clk_sys) begin
      event_in_a <= want_a;
      event_in_b <= want_b;
   end
endmodule
`default_nettype wire

// ===== tb/wave_timer_monitor.sv
// concurrent checks on the ports of the waveform timer
`timescale 1ns/1ps
`default_nettype none
module wave_timer_monitor (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        event_in_a,
   input wire logic        event_in_b,
   input wire logic        wave_out_a,
   input wire logic        wave_out_b
);
   logic ever_en;
   wire  map_ok  = (paddr[1:0] == 2'h0) && (paddr <= 12'h02C);
   wire  wr_ctrl = psel && penable && pwrite && (paddr == 12'h000);
   default clocking @(posedge clk_sys); endclocking
   // remembers whether the timer was ever switched on since reset
   always_ff @(posedge clk_sys or posedge sys_rst)
      if (sys_rst) ever_en <= 1'b0;
      else if (wr_ctrl && pwdata[0]) ever_en <= 1'b1;
   sequence s_access;
      psel && penable;
   endsequence
   a_ready_now: assert property (disable iff (sys_rst) s_access ##0 pwrite |-> pready)
      else $error("no ready in write access");
   a_read_ready: assert property (disable iff (sys_rst) s_access ##0 (!pwrite && !pready) |=> pready)
      else $error("read not ready after one wait state");
   a_err_unmapped: assert property (disable iff (sys_rst) psel && penable && !map_ok |-> pslverr)
      else $error("unmapped access without error");
   a_err_mapped: assert property (disable iff (sys_rst) psel && penable && map_ok |-> !pslverr)
      else $error("error on mapped access");
   a_err_setup: assert property (disable iff (sys_rst) psel && !penable |-> !pslverr)
      else $error("error in setup cycle");
   a_reset_quiet: assert property (disable iff (sys_rst) $fell(sys_rst) |-> !wave_out_a && !wave_out_b && prdata == 32'h0)
      else $error("outputs not idle after reset");
   a_idle_outputs: assert property (disable iff (sys_rst) !ever_en |-> !wave_out_a && !wave_out_b)
      else $error("output active before enable");
   a_stop_now: assert property (disable iff (sys_rst) wr_ctrl && !pwdata[0] |=> (!wave_out_a && !wave_out_b) [*2])
      else $error("outputs active after disable");
   a_rdata_hold: assert property (disable iff (sys_rst) !(psel && penable) |=> $stable(prdata))
      else $error("read data moved without access");
   a_bad_read_zero: assert property (disable iff (sys_rst) s_access ##0 (!pwrite && !map_ok) |=> prdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind wave_timer wave_timer_monitor mon (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .event_in_a, .event_in_b, .wave_out_a, .wave_out_b);
`default_nettype wire
